// *** include/baud_gen_cfg.svh ***
`ifndef BAUD_GEN_CFG_SVH
`define BAUD_GEN_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define BAUD_DIV_HIGH_OFS 8'h00
`define BAUD_DIV_LOW_OFS 8'h01
`define SERIAL_CTRL_TWO_OFS 8'h02
`define GEN_STATUS_OFS 8'h03

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DIV_UPPER_MSB 4
`define CTRL_TX_ON_BIT 3
`define CTRL_RX_ON_BIT 2
`define DIV_HIGH_RST 5'h00
`define DIV_LOW_RST 8'h04
`define OVERSAMPLE 5'h10

`endif

// *** include/baud_gen_pkg.sv ***
package baud_gen_pkg;
  typedef logic [12:0] divisor_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  typedef struct packed {
    logic rx_on;
    logic tx_on;
  } path_on_s;
endpackage

// *** rtl/uart_baud_rate_generator.sv ***
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`include "baud_gen_cfg.svh"

module uart_baud_rate_generator
  import baud_gen_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire reg_req_s req_i,
  input wire logic stop_mode_i,
  output logic [7:0] rdata_o,
  output logic tick16_o,
  output logic baud_tick_o,
  output logic rx_path_on_o,
  output logic tx_path_on_o,
  output logic pins_owned_o
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [4:0] high_buf_q;
  divisor_t combined_divisor_q;
  path_on_s path_q;
  logic armed_q;
  divisor_t cnt_q;
  logic [3:0] sub_q;
  logic running;
  logic wr_ok;

  // stop mode freezes bus writes too; reads still answer
  assign wr_ok = req_i.wr && !stop_mode_i;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      high_buf_q <= `DIV_HIGH_RST;
    end else if (wr_ok && hit(req_i.addr, `BAUD_DIV_HIGH_OFS)) begin
      high_buf_q <= req_i.wdata[`DIV_UPPER_MSB:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      combined_divisor_q <= {`DIV_HIGH_RST, `DIV_LOW_RST};
    end else if (wr_ok && hit(req_i.addr, `BAUD_DIV_LOW_OFS)) begin
      combined_divisor_q <= {high_buf_q, req_i.wdata};
    end
  end

  // armed stays set once an enable has been written to 1
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      path_q <= '0;
      armed_q <= 1'b0;
    end else if (wr_ok && hit(req_i.addr, `SERIAL_CTRL_TWO_OFS)) begin
      path_q.rx_on <= req_i.wdata[`CTRL_RX_ON_BIT];
      path_q.tx_on <= req_i.wdata[`CTRL_TX_ON_BIT];
      if (req_i.wdata[`CTRL_RX_ON_BIT] || req_i.wdata[`CTRL_TX_ON_BIT]) begin
        armed_q <= 1'b1;
      end
    end
  end

  assign running = armed_q && (combined_divisor_q != 13'h0000) && !stop_mode_i;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q <= 13'h0000;
      tick16_o <= 1'b0;
    end else if (!running) begin
      // stop keeps the count so the rate resumes in phase afterwards
      if (!stop_mode_i) begin
        cnt_q <= 13'h0000;
      end
      tick16_o <= 1'b0;
    // >= so a smaller divisor written mid-count wraps at once, not after 8191 cycles
    end else if (cnt_q >= combined_divisor_q - 13'h0001) begin
      cnt_q <= 13'h0000;
      tick16_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 13'h0001;
      tick16_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sub_q <= 4'h0;
      baud_tick_o <= 1'b0;
    end else if (!running) begin
      if (!stop_mode_i) begin
        sub_q <= 4'h0;
      end
      baud_tick_o <= 1'b0;
    end else begin
      if (cnt_q >= combined_divisor_q - 13'h0001) begin
        sub_q <= sub_q + 4'h1;
      end
      baud_tick_o <= (cnt_q >= combined_divisor_q - 13'h0001) && (sub_q == 4'hF);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      if (hit(req_i.addr, `BAUD_DIV_HIGH_OFS)) begin
        rdata_o <= {3'h0, combined_divisor_q[12:8]};
      end else if (hit(req_i.addr, `BAUD_DIV_LOW_OFS)) begin
        rdata_o <= combined_divisor_q[7:0];
      end else if (hit(req_i.addr, `SERIAL_CTRL_TWO_OFS)) begin
        rdata_o <= {4'h0, path_q.tx_on, path_q.rx_on, 2'h0};
      end else if (hit(req_i.addr, `GEN_STATUS_OFS)) begin
        rdata_o <= {6'h00, armed_q, running};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

  assign rx_path_on_o = path_q.rx_on;
  assign tx_path_on_o = path_q.tx_on;
  assign pins_owned_o = path_q.rx_on || path_q.tx_on;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_zero_stops;
    @(posedge ref_clk_i) disable iff (rst_i)
      (combined_divisor_q == 13'h0000) |=> !tick16_o;
  endproperty
  a_zero_stops: assert property (p_zero_stops) else $error("tick with zero divisor");

  property p_idle_unarmed;
    @(posedge ref_clk_i) disable iff (rst_i)
      !armed_q |=> !tick16_o && !baud_tick_o;
  endproperty
  a_idle_unarmed: assert property (p_idle_unarmed) else $error("tick before enable");

  property p_stop_halts;
    @(posedge ref_clk_i) disable iff (rst_i)
      stop_mode_i |=> !tick16_o && $stable(cnt_q);
  endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("runs in stop");

  property p_high_buffered;
    @(posedge ref_clk_i) disable iff (rst_i)
      (wr_ok && hit(req_i.addr, `BAUD_DIV_HIGH_OFS)) |=> $stable(combined_divisor_q);
  endproperty
  a_high_buffered: assert property (p_high_buffered) else $error("high byte not buffered");

  property p_low_loads;
    @(posedge ref_clk_i) disable iff (rst_i)
      (wr_ok && hit(req_i.addr, `BAUD_DIV_LOW_OFS))
        |=> combined_divisor_q == {$past(high_buf_q), $past(req_i.wdata)};
  endproperty
  a_low_loads: assert property (p_low_loads) else $error("divisor load wrong");

  property p_pins;
    @(posedge ref_clk_i) disable iff (rst_i)
      (wr_ok && hit(req_i.addr, `SERIAL_CTRL_TWO_OFS)
        && (req_i.wdata[`CTRL_RX_ON_BIT] || req_i.wdata[`CTRL_TX_ON_BIT])) |=> pins_owned_o;
  endproperty
  a_pins: assert property (p_pins) else $error("pins not owned");

  property p_tick_single;
    @(posedge ref_clk_i) disable iff (rst_i)
      (tick16_o && combined_divisor_q > 13'h0001) |=> !tick16_o;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick too long");

  property p_div2_period;
    @(posedge ref_clk_i) disable iff (rst_i)
      (tick16_o && running && combined_divisor_q == 13'h0002 && !stop_mode_i && !wr_ok)
        ##1 (running && !wr_ok) |=> tick16_o;
  endproperty
  a_div2_period: assert property (p_div2_period) else $error("rate wrong");

  c_tick: cover property (@(posedge ref_clk_i) tick16_o);
  c_baud: cover property (@(posedge ref_clk_i) baud_tick_o);
  c_stop: cover property (@(posedge ref_clk_i) running ##1 stop_mode_i);
  c_reload: cover property (@(posedge ref_clk_i)
    (wr_ok && hit(req_i.addr, `BAUD_DIV_LOW_OFS)) ##1 running);

  property p_wrap_resets;
    @(posedge ref_clk_i) disable iff (rst_i)
      (running && cnt_q >= combined_divisor_q - 13'h0001) |=> (cnt_q == 13'h0000) && tick16_o;
  endproperty
  a_wrap_resets: assert property (p_wrap_resets) else $error("wrap missed");

  property p_armed_sticky;
    @(posedge ref_clk_i) disable iff (rst_i)
      armed_q |=> armed_q;
  endproperty
  a_armed_sticky: assert property (p_armed_sticky) else $error("armed lost");

  property p_stop_no_write;
    @(posedge ref_clk_i) disable iff (rst_i)
      (req_i.wr && stop_mode_i)
        |=> $stable(combined_divisor_q) && $stable(high_buf_q) && $stable(path_q);
  endproperty
  a_stop_no_write: assert property (p_stop_no_write) else $error("write taken in stop");

  property p_read_high;
    @(posedge ref_clk_i) disable iff (rst_i)
      (req_i.rd && hit(req_i.addr, `BAUD_DIV_HIGH_OFS)) |=> (rdata_o[7:5] == 3'h0);
  endproperty
  a_read_high: assert property (p_read_high) else $error("high byte upper bits set");

endmodule

// *** dv/serial_peer_model.sv ***
`timescale 1ns/1ns
// ----
// far-side peer: measures tick spacing
// ----
module serial_peer_model (
  input wire logic clk_i,
  input wire logic tick16_i,
  input wire logic baud_tick_i,
  output int period_o,
  output int per_baud_o,
  output int ticks_o
);
  int cnt;
  int bcnt;
  // a real peer only sees edges, so spacing is all it can judge
  always @(posedge clk_i) begin
    cnt <= tick16_i ? 1 : cnt + 1;
    bcnt <= baud_tick_i ? 1 : bcnt + 1;
    if (tick16_i) begin
      period_o <= cnt;
      ticks_o <= ticks_o + 1;
    end
    if (baud_tick_i) begin
      per_baud_o <= bcnt;
    end
  end
endmodule

// *** dv/uart_baud_rate_generator_test.sv ***
`timescale 1ns/1ns
// ----
// bench
// ----
module uart_baud_rate_generator_test;
  import baud_gen_pkg::*;
  logic clk;
  logic rst;
  logic stop;
  reg_req_s req;
  logic [7:0] rdata;
  logic t16;
  logic bt;
  logic rx_on;
  logic tx_on;
  logic pins;
  int per;
  int pbaud;
  int ticks;
  int n;
  int cyc;
  int fail_count;
  int checked;
  uart_baud_rate_generator u_uart_baud_rate_generator (.ref_clk_i(clk), .rst_i(rst),
    .req_i(req), .stop_mode_i(stop), .rdata_o(rdata), .tick16_o(t16), .baud_tick_o(bt),
    .rx_path_on_o(rx_on), .tx_path_on_o(tx_on), .pins_owned_o(pins));
  serial_peer_model u_serial_peer_model (.clk_i(clk), .tick16_i(t16), .baud_tick_i(bt),
    .period_o(per), .per_baud_o(pbaud), .ticks_o(ticks));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  // one idle cycle after each strobe keeps every signal single-assigned per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask
  task automatic test_done();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    req <= '0;
    stop <= 1'b0;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h01, 8'h04);
    rd(8'h07, 8'h00);
    rd(8'h03, 8'h00);
    repeat (60) @(posedge clk);
    chk(ticks, 0);
    $display("reset test done");
    wr(8'h02, 8'h04);
    rd(8'h03, 8'h03);
    repeat (200) @(posedge clk);
    chk(per, 4);
    chk(pbaud, 64);
    chk(pins, 1'b1);
    wr(8'h00, 8'h01);
    repeat (40) @(posedge clk);
    chk(per, 4);
    wr(8'h01, 8'h00);
    repeat (12400) @(posedge clk);
    chk(per, 256);
    chk(pbaud, 4096);
    $display("divisor test done");
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h00);
    rd(8'h03, 8'h02);
    n = ticks;
    repeat (600) @(posedge clk);
    chk(ticks, n);
    wr(8'h01, 8'h03);
    repeat (20) @(posedge clk);
    stop <= 1'b1;
    repeat (3) @(posedge clk);
    n = ticks;
    wr(8'h01, 8'h09);
    repeat (50) @(posedge clk);
    chk(ticks, n);
    stop <= 1'b0;
    rd(8'h01, 8'h03);
    repeat (30) @(posedge clk);
    chk(per, 3);
    wr(8'h01, 8'h02);
    repeat (20) @(posedge clk);
    chk(per, 2);
    $display("stop test done");
    wr(8'h02, 8'h08);
    chk({rx_on, tx_on, pins}, 3'b011);
    $display("path test done");
    test_done();
  end
endmodule
